// ### dv/afesp_host.sv
// SPI host model that frames transfers towards the serial port.
`timescale 1ns/1ps
module afesp_host
(
    input  wire logic mclk,  // System clock.
    output logic      cs_n,  // Chip select, active low.
    output logic      sck,   // Serial clock.
    output logic      sdi,   // Serial data to the port.
    input  wire logic sdo    // Serial data pin level.
);
    // Idle levels at time zero: no frame open.
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One frame: command then n data bytes, four cycles per clock half.
    task automatic xfer(input logic m11, input logic [7:0] cmd, input int n,
                        input logic [63:0] wd, output logic [63:0] rd);
        logic [71:0] sh;
        sh = {cmd, wd};
        rd = '0;
        sck <= m11;  // Clock idles high in mode 1,1.
        tick(2);
        cs_n <= 1'b0;
        tick(2);
        for (int i = 0; i < 8 * (n + 1); i++)
        begin
            sck <= 1'b0;  // Port launches on the fall.
            sdi <= sh[71 - i];  // Command first, MSB first.
            tick(4);
            sck <= 1'b1;  // Port samples on the rise.
            tick(1);
            rd = {rd[62:0], sdo};
            tick(3);
        end
        sck <= m11;
        tick(4);
        cs_n <= 1'b1;
        sdi  <= ~sdi;  // A released line does not keep its level.
        tick(4);
    endtask
endmodule // afesp_host

// ### dv/afesp_port_tb.sv
// Self-checking bench for the serial register port.
`timescale 1ns/1ps
module afesp_port_tb;
    import afesp_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        new_sample = 1'b0;
    logic [23:0] ch0_data = 24'h000000;
    logic [23:0] ch1_data = 24'h000000;
    logic        cs_n, sck, sdi, sdo_o, sdo_oe, rdy_n, rdy_oe, mon;
    logic [7:0]  ls_q;
    logic [63:0] rd;
    int          n_fail = 0;
    int          n_checks = 0;
    int          oe_seen = 0;
    wire         sdo_pin = sdo_oe ? sdo_o : 1'bz;

    afesp_port #(.DEV_ADDR(2'b00)) DUT (.mclk(mclk), .rst_n(rst_n),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .new_sample(new_sample),
        .ch0_data(ch0_data), .ch1_data(ch1_data), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .sample_ready_n_o(rdy_n),
        .sample_ready_n_oe(rdy_oe), .link_setup_q(ls_q));
    afesp_host h (.mclk(mclk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo(sdo_pin));

    // Clock, and a count of output drive while it must stay released.
    initial
    begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (mon === 1'b1 && sdo_oe !== 1'b0)
            oe_seen++;

    task automatic check(input string s, input logic [63:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Write n bytes from index a, output watched for any drive.
    task automatic wr(input logic m, input logic [4:0] a, input int n,
                      input logic [63:0] d);
        mon = 1'b1;
        h.xfer(m, {2'b00, a, 1'b0}, n, d << (8 * (8 - n)), rd);
        mon = 1'b0;
    endtask

    // Read n bytes from index a and compare them with e.
    task automatic rdc(input string s, input logic m, input logic [4:0] a,
                       input int n, input logic [63:0] e);
        h.xfer(m, {2'b00, a, 1'b1}, n, 64'h0, rd);
        check(s, rd & ~(64'hFFFFFFFFFFFFFFFF << (8 * n)), e);
    endtask

    // Watchdog against a hung handshake.
    initial
    begin
        #3000000;
        n_fail++;
        wrap_up();
    end

    // Main sequence.
    initial
    begin
        mon = 1'b0;
        repeat (3) @(posedge mclk);
        check("setup in reset", ls_q, LS_RESET);
        check("oe in reset", {sdo_oe, rdy_oe}, 2'b00);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        ch0_data   <= 24'h123456;
        ch1_data   <= 24'h789ABC;
        new_sample <= 1'b1;
        @(posedge mclk);
        new_sample <= 1'b0;
        @(negedge mclk);
        check("ready low", {rdy_n, rdy_oe}, 2'b01);
        @(negedge mclk);
        check("ready idle", {rdy_n, rdy_oe}, 2'b10);
        rdc("type loop", 0, 5'h00, 7, 56'h123456789ABC12);
        wr(0, LINK_SETUP_IDX, 1, 8'h78);
        check("setup write", ls_q, 8'h78);
        rdc("group loop", 1, 5'h03, 4, 32'h789ABC78);
        wr(1, LINK_SETUP_IDX, 1, 8'h38);
        rdc("same byte", 0, 5'h04, 2, 16'h9A9A);
        wr(0, LINK_SETUP_IDX, 1, 8'hB0);
        rdc("short word", 0, 5'h00, 6, 48'h1234789ABC12);
        wr(0, LINK_SETUP_IDX, 1, 8'hF8);
        wr(0, 5'h19, 3, 24'hA1B2C3);
        rdc("map loop", 0, 5'h19, 3, 24'hA1B212);
        rdc("wrap", 0, 5'h06, 1, 8'hC3);
        wr(0, 5'h05, 2, 16'h5566);
        rdc("read only", 0, 5'h05, 2, 16'hBC66);
        // A stepped index would have wrapped to 0x06 and stored 0x88.
        wr(0, 5'h1B, 2, 16'h7788);
        rdc("undef write", 0, 5'h05, 2, 16'hBC66);
        rdc("undef read", 0, 5'h1C, 2, 16'h0000);
        wr(0, LINK_SETUP_IDX, 1, 8'hD8);
        wr(0, 5'h07, 2, 16'h1122);
        rdc("fixed index", 0, 5'h07, 2, 16'h2200);
        mon = 1'b1;
        h.xfer(0, 8'h54, 1, 64'h0, rd);
        h.xfer(0, 8'h41, 2, 64'h0, rd);
        mon = 1'b0;
        check("other chip", ls_q, 8'hD8);
        check("oe released", oe_seen, 0);
        // Ready pin driven high while idle, then released by hard reset.
        wr(0, LINK_SETUP_IDX, 1, 8'hDC);
        check("ready drive high", {rdy_n, rdy_oe}, 2'b11);
        rst_n <= 1'b0;
        @(negedge mclk);
        check("setup hard reset", ls_q, LS_RESET);
        check("oe hard reset", {sdo_oe, rdy_oe}, 2'b00);
        wrap_up();
    end
endmodule // afesp_port_tb

// ### rtl/afesp_link_if.sv
// Interface between the serial shift engine and the register core.
`timescale 1ns/1ps
interface afesp_link_if;
    logic [7:0] rx_byte;  // Byte just shifted in.
    logic       rx_stb;   // One-cycle pulse when rx_byte is complete.
    logic       frame;    // Chip select is low (synchronised).
    logic       sdo_bit;  // Serial output bit from the shifter.
    logic [7:0] tx_byte;  // Next byte to be shifted out.

    modport engine (output rx_byte, rx_stb, frame, sdo_bit, input tx_byte);
    modport core   (input rx_byte, rx_stb, frame, sdo_bit, output tx_byte);
endinterface // afesp_link_if

// ### rtl/afesp_pkg.sv
// Constants, field positions and types of the serial register port.
package afesp_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int         ADR_W          = 5;
    localparam logic [4:0] MAP_FIRST      = 5'h00;
    localparam logic [4:0] ADC_LAST       = 5'h05;
    localparam logic [4:0] CFG_FIRST      = 5'h06;
    localparam logic [4:0] MAP_LAST       = 5'h1A;
    localparam logic [4:0] LINK_SETUP_IDX = 5'h0A;
    localparam logic [4:0] CH0_LOW_IDX    = 5'h02;
    localparam logic [4:0] CH1_LOW_IDX    = 5'h05;
    localparam logic [4:0] ADR_STEP       = 5'h01;
    // Group bounds used by the read loop.
    localparam logic [4:0] G1_HI = 5'h02;
    localparam logic [4:0] G2_HI = 5'h05;
    localparam logic [4:0] G3_HI = 5'h09;
    localparam logic [4:0] G4_HI = 5'h0D;
    localparam logic [4:0] G5_HI = 5'h13;
    localparam logic [4:0] G6_HI = 5'h19;
    // ------------------------------------------------------------------
    // Link setup byte fields and reset values
    // ------------------------------------------------------------------
    localparam int         LS_LOOP_HI  = 7;
    localparam int         LS_LOOP_LO  = 6;
    localparam int         LS_WR_INC   = 5;
    localparam int         LS_WID1     = 4;
    localparam int         LS_WID0     = 3;
    localparam int         LS_DRV_HIGH = 2;
    localparam logic [7:0] LS_RESET    = 8'hB8;
    localparam logic [7:0] CFG_RESET   = 8'h00;
    localparam logic [1:0] LOOP_SAME   = 2'h0;
    localparam logic [1:0] LOOP_GROUP  = 2'h1;
    localparam logic [1:0] LOOP_TYPE   = 2'h2;
    localparam logic [1:0] LOOP_MAP    = 2'h3;
    // ------------------------------------------------------------------
    // Command byte fields
    // ------------------------------------------------------------------
    localparam int         CMD_CHIP_HI = 7;
    localparam int         CMD_CHIP_LO = 6;
    localparam int         CMD_IDX_HI  = 5;
    localparam int         CMD_IDX_LO  = 1;
    localparam int         CMD_DIR     = 0;
    localparam logic       DIR_READ    = 1'b1;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [2:0] BIT_FIRST   = 3'h0;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;

    // Transfer states.
    typedef enum logic [1:0] {
        ST_CMD    = 2'b00,
        ST_READ   = 2'b01,
        ST_WRITE  = 2'b10,
        ST_IGNORE = 2'b11
    } afesp_state_t;
endpackage

// ### rtl/afesp_port.sv
// Serial register port of a two-channel front end: top and register core.
//
// Overview of operation
// (R1) Output bits launch on falling clock, input bits sample on rising.
// (R2) Chip select frames each transfer; no state carries across frames.
// (R3) Chip select high: output released, clock and data ignored.
// (R4) First byte of each transfer is the command, then data bytes.
// (R5) Command holds chip address, five-bit index and direction bit.
// (R6) Respond only when chip address matches own address, default 00.
// (R7) Reads of undefined indexes return zero for every byte.
// (R8) Writes to undefined indexes store nothing and hold the counter.
// (R9) Reads start at the index; later indexes follow the loop setting.
// (R10) Auto-increment writes store then step the index per byte.
// (R11) Incrementing past the last entry wraps to the first writable.
// (R12) Without auto-increment every write byte targets one register.
// (R13) Bytes written to read-only locations are discarded.
// (R14) Output stays released through whole write transfers.
// (R15) Mode 1,1 clock idles high; first edge seen is falling.
// (R16) Pulse ready output low when new channel data arrives.
// (R17) Reset pin returns every register to its default value.
// (R18) Loop setting: same byte, group, type, or whole map.
// (R19) Groups: 00-02, 03-05, 06-09, 0A-0D, 0E-13, 14-19, 1A.
// (R20) Types: converter data 00-05, configuration 06-1A.
// (R21) With 16-bit width a looping read skips the channel low byte.
// (R22) Bytes shift MSB first; command LSB is direction, 1 reads.
// (R23) Address mismatch: output released, rest of transfer ignored.
// (R24) During reset writes are ignored and outputs are released.
`timescale 1ns/1ps
module afesp_port
    import afesp_pkg::*;
#(
    parameter logic [1:0] DEV_ADDR = 2'b00  // Own chip address.
)
(
    input  wire logic        mclk,              // System clock, 10 MHz.
    input  wire logic        rst_n,             // Reset pin, active low.
    input  wire logic        cs_n,              // Chip select, active low.
    input  wire logic        sck,               // Serial clock pin.
    input  wire logic        sdi,               // Serial data in pin.
    input  wire logic        new_sample,        // New channel data pulse.
    input  wire logic [23:0] ch0_data,          // Channel 0 result.
    input  wire logic [23:0] ch1_data,          // Channel 1 result.
    output logic             sdo_o,             // Serial data out level.
    output logic             sdo_oe,            // Serial out enable.
    output logic             sample_ready_n_o,  // Ready pin level.
    output logic             sample_ready_n_oe, // Ready pin enable.
    output logic [7:0]       link_setup_q       // Link setup byte.
);
    // ------------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------------
    afesp_link_if lk();

    afesp_shift u_shift (
        .mclk  (mclk),
        .rst_n (rst_n),
        .cs_n  (cs_n),
        .sck   (sck),
        .sdi   (sdi),
        .lk    (lk.engine)
    );

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    afesp_state_t state_reg;
    afesp_state_t state_next;
    logic [4:0]   addr_reg;
    logic [4:0]   addr_next;
    logic         undef_reg;
    logic [7:0]   cfg_reg [CFG_FIRST:MAP_LAST];
    logic [23:0]  ch0_reg;
    logic [23:0]  ch1_reg;
    logic         ready_reg;
    logic         sdo_reg;

    // ------------------------------------------------------------------
    // Index stepping helpers
    // ------------------------------------------------------------------
    // Next index inside [lo, hi], wrapping to lo.
    function automatic logic [4:0] step_in(input logic [4:0] a,
                                           input logic [4:0] lo,
                                           input logic [4:0] hi);
        step_in = (a >= hi) ? lo : a + ADR_STEP;
    endfunction

    // Lower bound of the group holding an index.
    function automatic logic [4:0] grp_lo(input logic [4:0] a);
        if (a <= G1_HI)      grp_lo = MAP_FIRST;              // see (R19)
        else if (a <= G2_HI) grp_lo = G1_HI + ADR_STEP;
        else if (a <= G3_HI) grp_lo = G2_HI + ADR_STEP;
        else if (a <= G4_HI) grp_lo = G3_HI + ADR_STEP;
        else if (a <= G5_HI) grp_lo = G4_HI + ADR_STEP;
        else if (a <= G6_HI) grp_lo = G5_HI + ADR_STEP;
        else                 grp_lo = MAP_LAST;
    endfunction

    // Upper bound of the group holding an index.
    function automatic logic [4:0] grp_hi(input logic [4:0] a);
        if (a <= G1_HI)      grp_hi = G1_HI;                  // see (R19)
        else if (a <= G2_HI) grp_hi = G2_HI;
        else if (a <= G3_HI) grp_hi = G3_HI;
        else if (a <= G4_HI) grp_hi = G4_HI;
        else if (a <= G5_HI) grp_hi = G5_HI;
        else if (a <= G6_HI) grp_hi = G6_HI;
        else                 grp_hi = MAP_LAST;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire [1:0] loop_mode = link_setup_q[LS_LOOP_HI:LS_LOOP_LO];
    wire       wr_inc    = link_setup_q[LS_WR_INC];
    wire       wid0_24   = link_setup_q[LS_WID0];
    wire       wid1_24   = link_setup_q[LS_WID1];
    wire       drv_high  = link_setup_q[LS_DRV_HIGH];

    wire [1:0] cmd_chip  = lk.rx_byte[CMD_CHIP_HI:CMD_CHIP_LO];  // see (R5)
    wire [4:0] cmd_idx   = lk.rx_byte[CMD_IDX_HI:CMD_IDX_LO];
    wire       cmd_read  = lk.rx_byte[CMD_DIR] == DIR_READ;      // see (R22)
    wire       chip_hit  = cmd_chip == DEV_ADDR;                  // see (R6)
    wire       addr_ok   = addr_reg <= MAP_LAST;
    wire       addr_cfg  = addr_reg >= CFG_FIRST;
    wire       wr_byte   = (state_reg == ST_WRITE) && lk.rx_stb;
    // Only defined, writable locations are stored. see (R8) (R13)
    wire       wr_store  = wr_byte && addr_ok && addr_cfg;

    // Loop bounds chosen by the loop setting. see (R18) (R20)
    logic [4:0] lp_lo;
    logic [4:0] lp_hi;
    always_comb
    begin
        case (loop_mode)
            LOOP_GROUP:
            begin
                lp_lo = grp_lo(addr_reg);
                lp_hi = grp_hi(addr_reg);
            end
            LOOP_TYPE:
            begin
                lp_lo = addr_cfg ? CFG_FIRST : MAP_FIRST;
                lp_hi = addr_cfg ? MAP_LAST : ADC_LAST;
            end
            LOOP_MAP:
            begin
                lp_lo = MAP_FIRST;
                lp_hi = MAP_LAST;
            end
            default:
            begin
                lp_lo = addr_reg;
                lp_hi = addr_reg;
            end
        endcase
    end

    // Read step, skipping a low data byte of a 16-bit channel.
    wire [4:0] rd_step1 = step_in(addr_reg, lp_lo, lp_hi);
    wire       rd_skip  = (loop_mode != LOOP_SAME) &&
                          (((rd_step1 == CH0_LOW_IDX) && !wid0_24) ||
                           ((rd_step1 == CH1_LOW_IDX) && !wid1_24));
    wire [4:0] rd_nxt   = rd_skip ? step_in(rd_step1, lp_lo, lp_hi)
                                  : rd_step1;  // see (R21)
    // Write step wraps from the last entry to the first writable one.
    wire [4:0] wr_nxt   = step_in(addr_reg, CFG_FIRST, MAP_LAST);  // see (R11)

    // Byte to send for the current index; zero where undefined.
    logic [7:0] rd_byte;
    always_comb
    begin
        case (addr_reg)
            5'h00:   rd_byte = ch0_reg[23:16];
            5'h01:   rd_byte = ch0_reg[15:8];
            5'h02:   rd_byte = ch0_reg[7:0];
            5'h03:   rd_byte = ch1_reg[23:16];
            5'h04:   rd_byte = ch1_reg[15:8];
            5'h05:   rd_byte = ch1_reg[7:0];
            default: rd_byte = addr_ok ? cfg_reg[addr_reg] : BYTE_ZERO;
        endcase
        if (undef_reg)
            rd_byte = BYTE_ZERO;  // see (R7)
    end
    assign lk.tx_byte = rd_byte;

    // ------------------------------------------------------------------
    // Transfer state machine
    // ------------------------------------------------------------------
    // Command first, then reads or writes until chip select rises.
    always_comb
    begin
        state_next = state_reg;
        addr_next  = addr_reg;
        case (state_reg)
            ST_CMD:
                if (lk.rx_stb)
                begin
                    addr_next = cmd_idx;  // see (R4) (R9)
                    if (!chip_hit)
                        state_next = ST_IGNORE;  // see (R23)
                    else if (cmd_read)
                        state_next = ST_READ;
                    else
                        state_next = ST_WRITE;
                end
            ST_READ:
                if (lk.rx_stb && !undef_reg)
                    addr_next = rd_nxt;  // see (R9)
            ST_WRITE:
                if (lk.rx_stb && addr_ok && wr_inc)
                    addr_next = wr_nxt;  // see (R10) (R12)
            ST_IGNORE:
                state_next = ST_IGNORE;
            default:
                state_next = ST_CMD;
        endcase
        if (!lk.frame)
            state_next = ST_CMD;  // see (R2) (R3)
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_CMD;
            addr_reg  <= MAP_FIRST;
            undef_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            if (state_reg == ST_CMD && lk.rx_stb)
                undef_reg <= cmd_idx > MAP_LAST;
        end
    end

    // ------------------------------------------------------------------
    // Registers and converter data
    // ------------------------------------------------------------------
    // Reset restores defaults; writes only reach writable entries.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = CFG_FIRST; i <= MAP_LAST; i++)
                cfg_reg[i] <= (i == LINK_SETUP_IDX) ? LS_RESET
                                                    : CFG_RESET;  // see (R17)
        end
        else if (wr_store)
            cfg_reg[addr_reg] <= lk.rx_byte;  // see (R13)
    end

    // Latch new results and pulse ready for one cycle.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch0_reg   <= 24'h000000;
            ch1_reg   <= 24'h000000;
            ready_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= new_sample;  // see (R16)
            if (new_sample)
            begin
                ch0_reg <= ch0_data;
                ch1_reg <= ch1_data;
            end
        end
    end

    // Output bit is retimed so the pin comes from a flop.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sdo_reg <= 1'b0;
        else
            sdo_reg <= lk.sdo_bit;
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    // Drive only in an addressed read inside the frame. see (R14) (R24)
    assign sdo_o             = sdo_reg;
    assign sdo_oe            = (state_reg == ST_READ) && lk.frame;  // see (R3)
    assign sample_ready_n_o  = ~ready_reg;
    assign sample_ready_n_oe = ready_reg | drv_high;  // see (R24)
    assign link_setup_q      = cfg_reg[LINK_SETUP_IDX];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_IDLE_RELEASED: assert property (@(posedge mclk)  // see (R3)
        disable iff (!rst_n) !lk.frame |-> !sdo_oe)
        else $error("serial output driven outside a frame");

    AST_WRITE_RELEASED: assert property (@(posedge mclk)  // see (R14)
        disable iff (!rst_n) state_reg == ST_WRITE |-> !sdo_oe)
        else $error("serial output driven during a write");

    AST_READY_PULSE: assert property (@(posedge mclk)  // see (R16)
        disable iff (!rst_n) new_sample ##1 !new_sample
        |-> !sample_ready_n_o ##1 sample_ready_n_o)
        else $error("ready pulse not one cycle after new data");

    AST_MISMATCH: assert property (@(posedge mclk)  // see (R23)
        disable iff (!rst_n)
        state_reg == ST_CMD && lk.rx_stb && lk.frame && !chip_hit
        |=> state_reg == ST_IGNORE)
        else $error("foreign chip address not ignored");

    AST_WRAP: assert property (@(posedge mclk)  // see (R11)
        disable iff (!rst_n)
        wr_byte && lk.frame && wr_inc && addr_reg == MAP_LAST
        |=> addr_reg == CFG_FIRST)
        else $error("write index did not wrap to first writable");

    AST_FIXED_WRITE: assert property (@(posedge mclk)  // see (R12)
        disable iff (!rst_n)
        wr_byte && lk.frame && !wr_inc |=> $stable(addr_reg))
        else $error("write index moved without auto-increment");

    AST_UNDEF_WRITE: assert property (@(posedge mclk)  // see (R8)
        disable iff (!rst_n) wr_byte && !addr_ok |=> $stable(addr_reg))
        else $error("undefined write advanced the index");

    AST_UNDEF_READ: assert property (@(posedge mclk)  // see (R7)
        disable iff (!rst_n)
        state_reg == ST_READ && undef_reg |-> lk.tx_byte == BYTE_ZERO)
        else $error("undefined read returned nonzero");

    AST_FRAME_END: assert property (@(posedge mclk)  // see (R2)
        disable iff (!rst_n) !lk.frame |=> state_reg == ST_CMD)
        else $error("transfer state survived chip select high");
endmodule // afesp_port

// ### rtl/afesp_shift.sv
// Serial shift engine: pin synchronisers, clock edge finder, shifters.
`timescale 1ns/1ps
module afesp_shift
    import afesp_pkg::*;
(
    input  wire logic   mclk,   // System clock.
    input  wire logic   rst_n,  // Asynchronous reset, active low.
    input  wire logic   cs_n,   // Chip select pin, active low.
    input  wire logic   sck,    // Serial clock pin.
    input  wire logic   sdi,    // Serial data in pin.
    afesp_link_if.engine lk     // Byte link to the register core.
);
    // ------------------------------------------------------------------
    // Synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       sck_d_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic [2:0] bit_cnt_reg;
    logic       rx_stb_reg;
    wire        frame_w = ~sync2_reg[2];
    wire        sck_s   = sync2_reg[1];
    wire        sdi_s   = sync2_reg[0];
    wire        sck_rise = frame_w & sck_s & ~sck_d_reg;
    wire        sck_fall = frame_w & ~sck_s & sck_d_reg;

    // Two flops on every pin; only the second stage is read.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            sck_d_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {cs_n, sck, sdi};
            sync2_reg <= sync1_reg;
            sck_d_reg <= sck_s;
        end
    end

    // ------------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------------
    // Sample on rising edges, MSB first; idle frames clear the bit count. see (R1)
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_sh_reg   <= BYTE_ZERO;
            bit_cnt_reg <= BIT_FIRST;
            rx_stb_reg  <= 1'b0;
        end
        else if (!frame_w)
        begin
            bit_cnt_reg <= BIT_FIRST;  // see (R2) (R3)
            rx_stb_reg  <= 1'b0;
        end
        else
        begin
            rx_stb_reg <= sck_rise && (bit_cnt_reg == BIT_LAST);
            if (sck_rise)
            begin
                rx_sh_reg   <= {rx_sh_reg[6:0], sdi_s};  // see (R22)
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------------
    // Launch on falling edges; a fall at a byte boundary loads the next
    // byte, which also covers the leading fall of mode 1,1. see (R15)
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tx_sh_reg <= BYTE_ZERO;
        else if (sck_fall)
        begin
            if (bit_cnt_reg == BIT_FIRST)
                tx_sh_reg <= lk.tx_byte;  // see (R1)
            else
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
    end

    assign lk.rx_byte = rx_sh_reg;
    assign lk.rx_stb  = rx_stb_reg;
    assign lk.frame   = frame_w;
    assign lk.sdo_bit = tx_sh_reg[7];

    // A byte is complete only after eight rising edges in the frame.
    AST_BYTE_AFTER_RISE: assert property (@(posedge mclk)  // see (R4)
        disable iff (!rst_n)
        rx_stb_reg |-> $past(sck_rise) && $past(bit_cnt_reg) == BIT_LAST)
        else $error("byte strobe without eighth rising edge");
endmodule // afesp_shift
